// ===== rtl/ssq_sequencer.sv
// Purpose: Sleep-state power sequencer control logic for a multi-rail part.
// Assumes: All inputs are asynchronous pins or comparator outputs.
// Notes: Ramps are modelled as timed phases; analog behaviour is outside.
`default_nettype none

// What this block does
// - Dual-5V sleep support tracks its pin only when active, off or starting.
// - Both sleep request inputs are deglitched; short pulses are ignored.
// - Sleep3 falling starts a timer; expiry picks deep or RAM sleep.
// - Standby POR release starts first ramp of dual 3.3V and 1.8V.
// - First ramp end enables their monitors and idles the ramp.
// - After a timeout, latch selections and start the second ramp.
// - Second ramp end enables remaining monitors; ramp idles.
// - Clock rail stays off in sleep; on only when active and supplies good.
// - Both requests high at bias-up means active wake after supply timeout.
// - Standby rails come up right after POR, regardless of requests.
// - Main timeout expiry starts memory and clock ramp and the switch gate.
// - After the active ramp the sequencer idles until a sleep request.
// - Any monitored output undervoltage raises the fault indication; clock rail undervoltage only in the active state.
// - Undervoltage on an externally passed rail only flags a fault.
// - Undervoltage on an on-chip passed rail flags and latches it off.
// - Shutdown disables rails, clears fault and rail-off latches; release restarts.
// - Early standby rail undervoltage latches the whole device off.
// - Low overtemp flags fault; high overtemp disables rails until cool.
// - Main supply loss while active forces deep sleep with a fault.
// - Forced deep sleep ends on supply recovery, POR or shutdown.
// - Memory voltage comparator is sampled once per start and latched.
// - Direct moves between the two sleep states are refused.
// - In sleep, dual 5V follows sleep support; when active, on once the main timeout expires.
module ssq_sequencer #(
  parameter int unsigned LATCH_CYC = ssq_pkg::LATCH_DELAY_CYC,
  parameter int unsigned MAIN_CYC = ssq_pkg::MAIN_DELAY_CYC,
  parameter int unsigned RAMP_LEN = ssq_pkg::RAMP_CYC
) (
  // Clock and standby power-on reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Sleep requests and selections
  input wire logic i_sleep3_request_n,
  input wire logic i_sleep5_request_n,
  input wire logic i_dual5_sleep_support,
  input wire logic i_memory_voltage_select,
  input wire logic i_shutdown,
  // Main supply good flags
  input wire logic i_main33_ok,
  input wire logic i_main5_ok,
  input wire logic i_main12_ok,
  // Output undervoltage flags and temperature comparators
  input wire logic i_uv_sb18,
  input wire logic i_uv_dual33,
  input wire logic i_uv_mem_int,
  input wire logic i_uv_mem_ext,
  input wire logic i_uv_clk,
  input wire logic i_uv_dual5,
  input wire logic i_temp_low,
  input wire logic i_temp_high,
  // Rail controls and indications
  output logic [4:0] o_rail_en,
  output logic o_active_switch_gate,
  output logic o_fault_and_memsel_pin,
  output logic o_mem_high_voltage,
  output logic o_dual5_sleep_latched,
  output logic o_monitors_early,
  output logic o_monitors_all,
  output logic [2:0] o_power_state
);
  logic [ssq_pkg::SYNC_W-1:0] raw, s1, s2, s3;
  logic [ssq_pkg::SYNC_W-1:0] sy;
  assign raw = {1'b0, i_uv_mem_ext, i_temp_high, i_temp_low, i_uv_dual5,
                i_uv_clk, i_uv_mem_int, i_uv_dual33, i_uv_sb18, i_main12_ok,
                i_main5_ok, i_main33_ok, i_shutdown, i_memory_voltage_select,
                i_dual5_sleep_support, i_sleep5_request_n, i_sleep3_request_n};

  // Three stages; a change counts once stages two and three agree.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sy <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      sy <= (s2 & s3) | (sy & (s2 | s3));
    end
  end

  // Request deglitch: a level must hold for the whole interval.
  // Requests read high from reset, matching their pulled-up idle level.
  logic [1:0] req;
  logic [7:0] dg_cnt [2];
  genvar g;
  for (g = 0; g < 2; g++) begin : g_dg
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        req[g] <= 1'b1;
        dg_cnt[g] <= '0;
      end else if (sy[g] == req[g]) begin
        dg_cnt[g] <= '0;
      end else if (dg_cnt[g] == 8'(ssq_pkg::DEGLITCH_CYC - 1)) begin
        req[g] <= sy[g];
        dg_cnt[g] <= '0;
      end else begin
        dg_cnt[g] <= dg_cnt[g] + 8'h01;
      end
    end
  end

  wire s3n = req[ssq_pkg::IX_S3];
  wire s5n = req[ssq_pkg::IX_S5];
  wire shdn = sy[ssq_pkg::IX_SHDN];
  wire mains_ok = sy[ssq_pkg::IX_OK33] & sy[ssq_pkg::IX_OK5]
                  & sy[ssq_pkg::IX_OK12];
  wire hot = sy[ssq_pkg::IX_THI];
  wire illegal_req = s3n & ~s5n;

  ssq_pkg::ssq_state_t state, next_state;
  ssq_pkg::ssq_pwr_t pwr;
  logic [ssq_pkg::CNT_W-1:0] cnt;
  logic [ssq_pkg::CNT_W-1:0] slp_cnt;
  logic slp_timing, forced_s5, dead, overheat, mon_early, mon_all;
  logic mem_off, clk_off, sb18_off, d5_sleep, mem_hi;

  wire ramp_done = cnt == ssq_pkg::CNT_W'(RAMP_LEN - 1);
  wire latch_done = cnt == ssq_pkg::CNT_W'(LATCH_CYC - 1);
  wire main_done = cnt == ssq_pkg::CNT_W'(MAIN_CYC - 1);
  wire slp_done = slp_cnt == ssq_pkg::CNT_W'(ssq_pkg::SLEEP_DELAY_CYC - 1);
  wire is_active = pwr == ssq_pkg::SSQ_PW_ACT;
  wire uv_early = sy[ssq_pkg::IX_UV18] | sy[ssq_pkg::IX_UV33D];

  always_comb begin
    next_state = state;
    case (state)
      ssq_pkg::SSQ_ST_OFF:
        next_state = ssq_pkg::SSQ_ST_RAMP1;
      ssq_pkg::SSQ_ST_RAMP1:
        if (ramp_done) next_state = ssq_pkg::SSQ_ST_WAIT;
      ssq_pkg::SSQ_ST_WAIT:
        if (latch_done) next_state = ssq_pkg::SSQ_ST_RAMP2;
      ssq_pkg::SSQ_ST_RAMP2:
        if (ramp_done) begin
          next_state = is_active ? ssq_pkg::SSQ_ST_ACTWAIT
                                 : ssq_pkg::SSQ_ST_SLEEP;
        end
      ssq_pkg::SSQ_ST_SLEEP:
        if (is_active) next_state = ssq_pkg::SSQ_ST_ACTWAIT;
      ssq_pkg::SSQ_ST_ACTWAIT:
        if (!is_active) next_state = ssq_pkg::SSQ_ST_SLEEP;
        else if (main_done) next_state = ssq_pkg::SSQ_ST_ACTIVE;
      ssq_pkg::SSQ_ST_ACTIVE:
        if (!is_active) next_state = ssq_pkg::SSQ_ST_SLEEP;
      default:
        next_state = ssq_pkg::SSQ_ST_OFF;
    endcase
  end

  // Shutdown and the whole-device latch hold the sequencer at its start.
  wire hold = shdn | dead;
  wire st_change = next_state != state;
  wire cnt_run = (state == ssq_pkg::SSQ_ST_ACTWAIT) ? mains_ok : 1'b1;
  wire timed = (state != ssq_pkg::SSQ_ST_SLEEP)
               && !(state == ssq_pkg::SSQ_ST_ACTIVE && ramp_done);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ssq_pkg::SSQ_ST_OFF;
      cnt <= '0;
    end else if (hold) begin
      state <= ssq_pkg::SSQ_ST_OFF;
      cnt <= '0;
    end else begin
      state <= next_state;
      if (st_change || !cnt_run) cnt <= '0;
      else if (timed) cnt <= cnt + 1'b1;
    end
  end

  // Sleep entry timer and power-state decisions.
  wire go_sleep = slp_timing && slp_done;
  wire act_loss = is_active && state == ssq_pkg::SSQ_ST_ACTIVE && !mains_ok;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr <= ssq_pkg::SSQ_PW_S5;
      slp_timing <= 1'b0;
      slp_cnt <= '0;
      forced_s5 <= 1'b0;
    end else if (shdn) begin
      forced_s5 <= 1'b0;
      slp_timing <= 1'b0;
      slp_cnt <= '0;
      if (state == ssq_pkg::SSQ_ST_OFF && s3n && s5n) begin
        pwr <= ssq_pkg::SSQ_PW_ACT;
      end
    end else if (forced_s5) begin
      if (mains_ok) forced_s5 <= 1'b0;
    end else if (act_loss) begin
      pwr <= ssq_pkg::SSQ_PW_S5;
      forced_s5 <= 1'b1;
    end else if (is_active) begin
      if (s3n) begin
        slp_timing <= 1'b0;
        slp_cnt <= '0;
      end else if (go_sleep) begin
        pwr <= s5n ? ssq_pkg::SSQ_PW_S3 : ssq_pkg::SSQ_PW_S5;
        slp_timing <= 1'b0;
      end else begin
        slp_timing <= 1'b1;
        slp_cnt <= slp_timing ? slp_cnt + 1'b1 : '0;
      end
    end else if (s3n && s5n) begin
      pwr <= ssq_pkg::SSQ_PW_ACT;
    end else if (illegal_req) begin
      pwr <= pwr;
    end
  end

  // Selections, fault latches and monitor enables.
  wire d5_open = is_active || state == ssq_pkg::SSQ_ST_OFF ||
                 state == ssq_pkg::SSQ_ST_RAMP1 ||
                 state == ssq_pkg::SSQ_ST_WAIT;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      d5_sleep <= 1'b0;
      mem_hi <= 1'b0;
      dead <= 1'b0;
      overheat <= 1'b0;
      sb18_off <= 1'b0;
      mem_off <= 1'b0;
      clk_off <= 1'b0;
      mon_early <= 1'b0;
      mon_all <= 1'b0;
    end else begin
      if (d5_open && !hold) d5_sleep <= sy[ssq_pkg::IX_D5];
      if (state == ssq_pkg::SSQ_ST_WAIT && latch_done) begin
        mem_hi <= sy[ssq_pkg::IX_MEMORY_VOLTAGE_SELECT];
      end
      if (mon_early && !mon_all && uv_early) dead <= 1'b1;
      if (hot) overheat <= 1'b1;
      else if (!sy[ssq_pkg::IX_TLO]) overheat <= 1'b0;
      if (shdn) begin
        mem_off <= 1'b0;
        clk_off <= 1'b0;
        sb18_off <= 1'b0;
        mon_early <= 1'b0;
        mon_all <= 1'b0;
      end else begin
        if (mon_all && sy[ssq_pkg::IX_UVMEM]) mem_off <= 1'b1;
        if (mon_all && sy[ssq_pkg::IX_UVCLK]) clk_off <= 1'b1;
        if (mon_all && sy[ssq_pkg::IX_UV18]) sb18_off <= 1'b1;
        if (state == ssq_pkg::SSQ_ST_RAMP1 && ramp_done) begin
          mon_early <= 1'b1;
        end
        if (state == ssq_pkg::SSQ_ST_RAMP2 && ramp_done) begin
          mon_all <= 1'b1;
        end
      end
    end
  end

  wire uv_any = (mon_early && uv_early) || (mon_all && (sy[ssq_pkg::IX_UVMEM]
                | sy[ssq_pkg::IX_UVMEMX] | sy[ssq_pkg::IX_UV5D]
                | (sy[ssq_pkg::IX_UVCLK] && state == ssq_pkg::SSQ_ST_ACTIVE)));
  wire next_fault = !shdn && (uv_any || dead || forced_s5 || overheat
                    || sy[ssq_pkg::IX_TLO]);
  wire rails_ok = !hold && !overheat;
  wire up_main = state == ssq_pkg::SSQ_ST_ACTIVE;
  wire past_ramp2 = state == ssq_pkg::SSQ_ST_SLEEP
                    || state == ssq_pkg::SSQ_ST_ACTWAIT || up_main;
  ssq_pkg::ssq_rails_t next_rails;
  always_comb begin
    next_rails.dual33 = rails_ok;
    next_rails.sb18 = rails_ok && !sb18_off;
    next_rails.mem = rails_ok && !mem_off && (is_active ? up_main
                     : (state == ssq_pkg::SSQ_ST_RAMP2 || past_ramp2));
    next_rails.clk = rails_ok && !clk_off && up_main && mains_ok;
    next_rails.dual5 = rails_ok && (is_active ? up_main
                       : d5_sleep && (state == ssq_pkg::SSQ_ST_RAMP2
                       || past_ramp2));
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rail_en <= '0;
      o_active_switch_gate <= 1'b0;
      o_fault_and_memsel_pin <= 1'b0;
    end else begin
      o_rail_en <= next_rails;
      o_active_switch_gate <= rails_ok && up_main;
      o_fault_and_memsel_pin <= next_fault;
    end
  end

  assign o_mem_high_voltage = mem_hi;
  assign o_dual5_sleep_latched = d5_sleep;
  assign o_monitors_early = mon_early;
  assign o_monitors_all = mon_all;
  assign o_power_state = pwr;
endmodule
`default_nettype wire

// ===== rtl/ssq_pkg.sv
// Purpose: Shared constants and carrier types of the sleep-state sequencer.
// Assumes: 10 MHz sequencer clock.
// Notes: Times are in nanoseconds; cycle counts derive from the clock period.
`default_nettype none
package ssq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned DEGLITCH_NS = 2000;
  localparam int unsigned SLEEP_DELAY_NS = 200000;
  localparam int unsigned LATCH_DELAY_NS = 3000000;
  localparam int unsigned MAIN_DELAY_NS = 25000000;
  localparam int unsigned RAMP_NS = 1000000;
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_DELAY_CYC = SLEEP_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned LATCH_DELAY_CYC = LATCH_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned MAIN_DELAY_CYC = MAIN_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned RAMP_CYC = RAMP_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned SYNC_W = 17;

  // Bit positions of the synchronised input vector.
  localparam int unsigned IX_S3 = 0;
  localparam int unsigned IX_S5 = 1;
  localparam int unsigned IX_D5 = 2;
  localparam int unsigned IX_MEMORY_VOLTAGE_SELECT = 3;
  localparam int unsigned IX_SHDN = 4;
  localparam int unsigned IX_OK33 = 5;
  localparam int unsigned IX_OK5 = 6;
  localparam int unsigned IX_OK12 = 7;
  localparam int unsigned IX_UV18 = 8;
  localparam int unsigned IX_UV33D = 9;
  localparam int unsigned IX_UVMEM = 10;
  localparam int unsigned IX_UVCLK = 11;
  localparam int unsigned IX_UV5D = 12;
  localparam int unsigned IX_TLO = 13;
  localparam int unsigned IX_THI = 14;
  localparam int unsigned IX_UVMEMX = 15;
  localparam int unsigned IX_SPARE = 16;

  typedef enum logic [6:0] {
    SSQ_ST_OFF = 7'b000_0001,
    SSQ_ST_RAMP1 = 7'b000_0010,
    SSQ_ST_WAIT = 7'b000_0100,
    SSQ_ST_RAMP2 = 7'b000_1000,
    SSQ_ST_SLEEP = 7'b001_0000,
    SSQ_ST_ACTWAIT = 7'b010_0000,
    SSQ_ST_ACTIVE = 7'b100_0000
  } ssq_state_t;

  typedef enum logic [2:0] {
    SSQ_PW_ACT = 3'b001,
    SSQ_PW_S3 = 3'b010,
    SSQ_PW_S5 = 3'b100
  } ssq_pwr_t;

  typedef struct packed {
    logic dual33;
    logic sb18;
    logic mem;
    logic clk;
    logic dual5;
  } ssq_rails_t;
endpackage
`default_nettype wire

// ===== verif/ssq_properties.sv
// Purpose: Port-level checks of the sleep-state sequencer.
// Assumes: Bound to the sequencer with its shortened counts.
// Notes: Input windows of 8 cycles cover synchronisers and output registers; the sleep clock check uses 4.
`default_nettype none
module ssq_properties #(
  parameter int unsigned LATCH_CYC = 20,
  parameter int unsigned MAIN_CYC = 30,
  parameter int unsigned RAMP_LEN = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Requests, selections and supplies
  input wire logic i_sleep3_request_n,
  input wire logic i_sleep5_request_n,
  input wire logic i_dual5_sleep_support,
  input wire logic i_memory_voltage_select,
  input wire logic i_shutdown,
  input wire logic i_main33_ok,
  input wire logic i_main5_ok,
  input wire logic i_main12_ok,
  // Monitors
  input wire logic i_uv_sb18,
  input wire logic i_uv_dual33,
  input wire logic i_uv_mem_int,
  input wire logic i_uv_mem_ext,
  input wire logic i_uv_clk,
  input wire logic i_uv_dual5,
  input wire logic i_temp_low,
  input wire logic i_temp_high,
  // Watched outputs
  input wire logic [4:0] o_rail_en,
  input wire logic o_active_switch_gate,
  input wire logic o_fault_and_memsel_pin,
  input wire logic o_mem_high_voltage,
  input wire logic o_dual5_sleep_latched,
  input wire logic o_monitors_early,
  input wire logic o_monitors_all,
  input wire logic [2:0] o_power_state
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_shdn;
    i_shutdown [*8];
  endsequence
  sequence s_loss;
    (o_power_state == 3'h1 && o_active_switch_gate && !i_main5_ok)
      ##1 (!i_main5_ok) [*7];
  endsequence
  property p_clk_active;
    $rose(o_rail_en[1]) |-> o_power_state == 3'h1;
  endproperty
  property p_gate_mem;
    $rose(o_active_switch_gate) |-> o_rail_en[2] && o_rail_en[1];
  endproperty
  property p_no_clk_sleep;
    (o_power_state != 3'h1) [*4] |-> !o_rail_en[1];
  endproperty
  property p_shdn;
    s_shdn |-> o_rail_en == 5'h00 && !o_fault_and_memsel_pin;
  endproperty
  property p_hot;
    i_temp_high [*8] |-> o_rail_en == 5'h00;
  endproperty
  property p_uv;
    (i_uv_mem_ext && o_monitors_all && !i_shutdown) [*8]
      |-> o_fault_and_memsel_pin;
  endproperty
  property p_loss;
    s_loss and (!i_shutdown) [*8] |-> o_power_state == 3'h4;
  endproperty
  property p_onehot;
    $onehot(o_power_state);
  endproperty
  property p_swap;
    o_power_state == 3'h2 && !i_shutdown |=> o_power_state != 3'h4;
  endproperty
  a_clk_active: assert property (p_clk_active) else $error("clk on");
  a_gate_mem: assert property (p_gate_mem) else $error("gate");
  a_no_clk_sleep: assert property (p_no_clk_sleep) else $error("clk");
  a_shdn: assert property (p_shdn) else $error("shutdown");
  a_hot: assert property (p_hot) else $error("overheat");
  a_uv: assert property (p_uv) else $error("uv fault");
  a_loss: assert property (p_loss) else $error("mains loss");
  a_onehot: assert property (p_onehot) else $error("state");
  a_swap: assert property (p_swap) else $error("sleep swap");
endmodule
bind ssq_sequencer ssq_properties #(.LATCH_CYC(LATCH_CYC),
  .MAIN_CYC(MAIN_CYC), .RAMP_LEN(RAMP_LEN)) u_chk (.*);
`default_nettype wire

// ===== verif/ssq_partner.sv
// Purpose: Chipset sleep lines and supply monitors facing the sequencer.
// Assumes: Command 0 is active, 1 is RAM sleep, 2 is deep sleep.
// Notes: Lines move at the falling edge, one step per cycle.
`default_nettype none
module ssq_partner (
  // Clock and commands
  input wire logic i_clk,
  input wire logic [1:0] i_cmd,
  input wire logic [2:0] i_mains,
  // Lines to the sequencer
  output logic o_sleep3_request_n,
  output logic o_sleep5_request_n,
  output logic o_main33_ok,
  output logic o_main5_ok,
  output logic o_main12_ok
);
  assign o_main33_ok = i_mains[0];
  assign o_main5_ok = i_mains[1];
  assign o_main12_ok = i_mains[2];
  // Sleep5 only falls after sleep3 and rises before it.
  always @(negedge i_clk) begin
    if (i_cmd == 2'h0) begin
      o_sleep5_request_n <= 1'b1;
      if (o_sleep5_request_n) o_sleep3_request_n <= 1'b1;
    end else begin
      o_sleep3_request_n <= 1'b0;
      if (!o_sleep3_request_n) o_sleep5_request_n <= (i_cmd != 2'h2);
    end
  end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: Self-checking bench of the sleep-state sequencer.
// Assumes: Shortened counts of 20, 30 and 10 cycles.
// Notes: Expected state is tracked in exp_ps from the commands given.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_b, i_sleep3_request_n, i_sleep5_request_n;
  logic i_dual5_sleep_support, i_memory_voltage_select, i_shutdown;
  logic i_main33_ok, i_main5_ok, i_main12_ok, i_temp_low, i_temp_high;
  logic i_uv_sb18, i_uv_dual33, i_uv_mem_int, i_uv_mem_ext;
  logic i_uv_clk, i_uv_dual5, o_active_switch_gate, o_fault_and_memsel_pin;
  logic o_mem_high_voltage, o_dual5_sleep_latched;
  logic o_monitors_early, o_monitors_all;
  logic [4:0] o_rail_en;
  logic [2:0] o_power_state, mains;
  logic [1:0] cmd;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int exp_ps;
  ssq_sequencer #(.LATCH_CYC(20), .MAIN_CYC(30), .RAMP_LEN(10)) u_dut (.*);
  ssq_partner u_far (.i_clk(i_clk), .i_cmd(cmd), .i_mains(mains),
    .o_sleep3_request_n(i_sleep3_request_n),
    .o_sleep5_request_n(i_sleep5_request_n), .o_main33_ok(i_main33_ok),
    .o_main5_ok(i_main5_ok), .o_main12_ok(i_main12_ok));
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait, then the state is compared with the model.
  task automatic wait_ps(input int lim);
    int n;
    n = 0;
    while (o_power_state !== 3'(exp_ps) && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk(8'(o_power_state), 8'(exp_ps));
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // A hang costs a mismatch; the run needs about 6800 cycles.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(94));
    {i_rst_b, i_shutdown, i_temp_low, i_temp_high, i_uv_mem_ext} = '0;
    {i_uv_sb18, i_uv_dual33, i_uv_mem_int, i_uv_clk, i_uv_dual5} = '0;
    i_memory_voltage_select = 1'($urandom % 2);
    i_dual5_sleep_support = 1'($urandom % 2);
    cmd = 2'h0;
    mains = 3'h0;
    exp_ps = 4;
    repeat (10) @(negedge i_clk);
    chk(8'(o_power_state), 8'h04);
    chk(8'(o_rail_en), 8'h00);
    i_rst_b = 1'b1;
    repeat (8) @(negedge i_clk);
    chk(8'(o_rail_en[4:3]), 8'h03);
    repeat (80) @(negedge i_clk);
    chk(8'(o_monitors_all), 8'h01);
    chk(8'(o_monitors_early), 8'h01);
    chk(8'(o_mem_high_voltage), 8'(i_memory_voltage_select));
    chk(8'(o_dual5_sleep_latched), 8'(i_dual5_sleep_support));
    chk(8'({o_rail_en[1], o_active_switch_gate}), 8'h00);
    mains = 3'h7;
    repeat (20) @(negedge i_clk);
    chk(8'(o_active_switch_gate), 8'h00);
    exp_ps = 1;
    wait_ps(200);
    repeat (20) @(negedge i_clk);
    chk(8'({o_rail_en, o_active_switch_gate}), 8'h3f);
    cmd = 2'h1;
    repeat (10) @(negedge i_clk);
    cmd = 2'h0;
    repeat (2100) @(negedge i_clk);
    chk(8'(o_power_state), 8'(exp_ps));
    cmd = 2'h1;
    exp_ps = 2;
    wait_ps(2200);
    repeat (3) @(negedge i_clk);
    chk(8'({o_rail_en[1], o_active_switch_gate}), 8'h00);
    chk(8'(o_rail_en[0]), 8'(i_dual5_sleep_support));
    i_dual5_sleep_support = !i_dual5_sleep_support;
    cmd = 2'h2;
    repeat (2100) @(negedge i_clk);
    chk(8'(o_power_state), 8'(exp_ps));
    chk(8'(o_dual5_sleep_latched), 8'(!i_dual5_sleep_support));
    cmd = 2'h0;
    exp_ps = 1;
    wait_ps(3000);
    repeat (40) @(negedge i_clk);
    i_uv_mem_ext = 1'b1;
    repeat (10) @(negedge i_clk);
    chk(8'(o_fault_and_memsel_pin), 8'h01);
    chk(8'(o_rail_en), 8'h1f);
    i_uv_mem_ext = 1'b0;
    i_uv_mem_int = 1'b1;
    repeat (10) @(negedge i_clk);
    chk(8'({o_rail_en, o_fault_and_memsel_pin}), 8'h37);
    i_uv_mem_int = 1'b0;
    {i_temp_low, i_temp_high} = 2'h3;
    repeat (10) @(negedge i_clk);
    chk(8'({o_rail_en, o_fault_and_memsel_pin}), 8'h01);
    {i_temp_low, i_temp_high} = 2'h0;
    i_shutdown = 1'b1;
    repeat (10) @(negedge i_clk);
    chk(8'({o_rail_en, o_fault_and_memsel_pin}), 8'h00);
    i_shutdown = 1'b0;
    wait_ps(500);
    repeat (100) @(negedge i_clk);
    chk(8'({o_rail_en, o_active_switch_gate}), 8'h3f);
    mains = 3'h5;
    exp_ps = 4;
    repeat (10) @(negedge i_clk);
    chk(8'(o_power_state), 8'(exp_ps));
    chk(8'(o_fault_and_memsel_pin), 8'h01);
    mains = 3'h7;
    exp_ps = 1;
    wait_ps(100);
    i_shutdown = 1'b1;
    repeat (10) @(negedge i_clk);
    i_shutdown = 1'b0;
    repeat (25) @(negedge i_clk);
    i_uv_dual33 = 1'b1;
    repeat (10) @(negedge i_clk);
    chk(8'({o_rail_en, o_fault_and_memsel_pin}), 8'h01);
    i_uv_dual33 = 1'b0;
    repeat (20) @(negedge i_clk);
    chk(8'({o_rail_en, o_fault_and_memsel_pin}), 8'h01);
    i_rst_b = 1'b0;
    repeat (10) @(negedge i_clk);
    chk(8'(o_power_state), 8'h04);
    i_rst_b = 1'b1;
    repeat (100) @(negedge i_clk);
    chk(8'({o_rail_en, o_active_switch_gate}), 8'h3f);
    final_report();
  end
endmodule
`default_nettype wire
